// ===== hdl/cxd_top.v
// Notes on behaviour
// (RULE1) XOR opcodes B2-B9: V clear, Z/S updated
// (RULE2) Six condition bits track last operation
// (RULE3) Jumps test only carry, overflow, zero, sign
// (RULE4) Half-carry and decimal-adjust never jump-testable
// (RULE5) Two user bits changed only explicitly
// (RULE6) User bits never offered as jump conditions
// (RULE7) User bits unknown at power-up, reset-immune
// (RULE8) Interrupt, trap, illegal trap push status
// (RULE9) Interrupt return reloads status from stack
// (RULE10) Displacement is signed eight-bit value
// (RULE11) ALU families share XOR operand-mode decode
// (RULE12) Fixed bit positions, kept through save/restore
//
// The APB interface to the registers and the address map were left to the implementer.
`include "cxd_defs.vh"

module cxd_top (
    // Clock and reset
    input wire CLK_I,
    input wire RESET_N_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // Execute request
    input wire EXEC_I,
    input wire [7:0] OPCODE_I,
    input wire [7:0] DST_I,
    input wire [7:0] SRC_I,
    output reg [7:0] RESULT_O,
    output reg RESULT_WE_O,
    // User bit instructions
    input wire [1:0] USER_SET_I,
    input wire [1:0] USER_CLR_I,
    // Conditional jump test
    input wire [2:0] COND_SEL_I,
    output reg COND_TRUE_O,
    // Indexed and relative addressing
    input wire [15:0] BASE_I,
    input wire [7:0] DISP_I,
    output reg [15:0] EA_O,
    // Stack save and restore
    input wire INT_TAKE_I,
    input wire TRAP_I,
    input wire ILLEGAL_I,
    input wire INTERRUPT_RETURN_OP_I,
    input wire [7:0] STACK_DATA_I,
    output reg STACK_WE_O,
    output reg [7:0] STACK_DATA_O,
    // Status
    output reg [7:0] FLAGS_O
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg carry;
    reg zero;
    reg sign;
    reg ovfl;
    reg decadj;
    reg half;
    reg user_status_bit_one;
    reg user_status_bit_two;
    reg enable;
    reg dec_valid;
    reg dec_ext;
    reg [3:0] dec_family;
    reg [2:0] dec_mode;
    reg [7:0] last_result;

    // ----------------------------------------
    // Decode and ALU
    // ----------------------------------------
    wire [3:0] op_hi = OPCODE_I[7:4];
    wire [3:0] op_lo = OPCODE_I[3:0];
    wire [3:0] mode_off = op_lo - `CXD_MODE_FIRST;
    wire [7:0] flags_now;
    reg fam_ok;
    reg mode_ok;
    reg is_logic;
    reg use_cin;
    reg is_sub;
    reg [8:0] wide;
    reg [4:0] nib;
    reg [7:0] next_result;
    reg next_carry;
    reg next_zero;
    reg next_sign;
    reg next_ovfl;
    reg next_decadj;
    reg next_half;

    assign flags_now = {carry, zero, sign, ovfl, decadj, half,
                        user_status_bit_two, user_status_bit_one}; // RULE12

    always @* begin
        fam_ok = 1'b1;
        is_logic = 1'b0;
        use_cin = 1'b0;
        is_sub = 1'b0;
        case (op_hi) // RULE11
            `CXD_FAM_ADD: begin
                is_sub = 1'b0;
            end
            `CXD_FAM_ADC: begin
                use_cin = 1'b1;
            end
            `CXD_FAM_SUB: begin
                is_sub = 1'b1;
            end
            `CXD_FAM_SBC: begin
                is_sub = 1'b1;
                use_cin = 1'b1;
            end
            `CXD_FAM_OR: begin
                is_logic = 1'b1;
            end
            `CXD_FAM_XOR: begin
                is_logic = 1'b1; // RULE1
            end
            default: begin
                fam_ok = 1'b0;
            end
        endcase
        mode_ok = (op_lo >= `CXD_MODE_FIRST) && (op_lo <= `CXD_MODE_LAST); // RULE1
        if (is_sub) begin
            wide = {1'b0, DST_I} - {1'b0, SRC_I} - {8'h00, use_cin & carry};
            nib = {1'b0, DST_I[3:0]} - {1'b0, SRC_I[3:0]} - {4'h0, use_cin & carry};
        end else begin
            wide = {1'b0, DST_I} + {1'b0, SRC_I} + {8'h00, use_cin & carry};
            nib = {1'b0, DST_I[3:0]} + {1'b0, SRC_I[3:0]} + {4'h0, use_cin & carry};
        end
        if (op_hi == `CXD_FAM_XOR) begin
            next_result = DST_I ^ SRC_I; // RULE1
        end else if (is_logic) begin
            next_result = DST_I | SRC_I;
        end else begin
            next_result = wide[7:0];
        end
        next_zero = (next_result == 8'h00); // RULE2
        next_sign = next_result[7];
        if (is_logic) begin
            // Logic ops touch only Z, S and V
            next_carry = carry; // RULE1
            next_ovfl = 1'b0;
            next_decadj = decadj;
            next_half = half;
        end else begin
            next_carry = wide[8];
            next_decadj = is_sub;
            next_half = nib[4];
            if (is_sub) begin
                next_ovfl = (DST_I[7] != SRC_I[7]) && (next_result[7] != DST_I[7]);
            end else begin
                next_ovfl = (DST_I[7] == SRC_I[7]) && (next_result[7] != DST_I[7]);
            end
        end
    end

    wire do_exec = EXEC_I & enable & fam_ok & mode_ok;

    // ----------------------------------------
    // Condition bits
    // ----------------------------------------
    // Reload from stack has priority, then execute, then software write
    wire apb_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
    wire wr_flags = apb_wr && (PADDR_I == `CXD_OFS_FLAGS);
    wire wr_ctrl = apb_wr && (PADDR_I == `CXD_OFS_CTRL);

    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            {carry, zero, sign, ovfl, decadj, half} <= `CXD_RST_COND;
        end else if (INTERRUPT_RETURN_OP_I) begin
            carry <= STACK_DATA_I[`CXD_BIT_CARRY]; // RULE9
            zero <= STACK_DATA_I[`CXD_BIT_ZERO];
            sign <= STACK_DATA_I[`CXD_BIT_SIGN];
            ovfl <= STACK_DATA_I[`CXD_BIT_OVFL];
            decadj <= STACK_DATA_I[`CXD_BIT_DECADJ];
            half <= STACK_DATA_I[`CXD_BIT_HALF];
        end else if (do_exec) begin
            carry <= next_carry; // RULE2
            zero <= next_zero;
            sign <= next_sign;
            ovfl <= next_ovfl;
            decadj <= next_decadj;
            half <= next_half;
        end else if (wr_flags) begin
            carry <= PWDATA_I[`CXD_BIT_CARRY];
            zero <= PWDATA_I[`CXD_BIT_ZERO];
            sign <= PWDATA_I[`CXD_BIT_SIGN];
            ovfl <= PWDATA_I[`CXD_BIT_OVFL];
            decadj <= PWDATA_I[`CXD_BIT_DECADJ];
            half <= PWDATA_I[`CXD_BIT_HALF];
        end
    end

    // ----------------------------------------
    // User bits
    // ----------------------------------------
    // Deliberately outside reset; they power up unknown
    always @(posedge CLK_I) begin
        if (INTERRUPT_RETURN_OP_I) begin
            user_status_bit_one <= STACK_DATA_I[`CXD_BIT_USER_ONE]; // RULE9
            user_status_bit_two <= STACK_DATA_I[`CXD_BIT_USER_TWO];
        end else if (wr_flags) begin
            user_status_bit_one <= PWDATA_I[`CXD_BIT_USER_ONE]; // RULE5
            user_status_bit_two <= PWDATA_I[`CXD_BIT_USER_TWO];
        end else begin
            // Set beats clear when both arrive together
            if (USER_SET_I[0]) begin
                user_status_bit_one <= 1'b1; // RULE5
            end else if (USER_CLR_I[0]) begin
                user_status_bit_one <= 1'b0;
            end
            if (USER_SET_I[1]) begin
                user_status_bit_two <= 1'b1;
            end else if (USER_CLR_I[1]) begin
                user_status_bit_two <= 1'b0;
            end
        end
    end // RULE7

    // ----------------------------------------
    // Execute results and decode status
    // ----------------------------------------
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RESULT_O <= `CXD_RST_BYTE;
            RESULT_WE_O <= 1'b0;
            last_result <= `CXD_RST_BYTE;
            dec_valid <= 1'b0;
            dec_ext <= 1'b0;
            dec_family <= 4'h0;
            dec_mode <= 3'h0;
        end else begin
            RESULT_WE_O <= do_exec;
            if (do_exec) begin
                RESULT_O <= next_result;
                last_result <= next_result;
            end
            if (EXEC_I) begin
                dec_valid <= fam_ok & mode_ok; // RULE11
                dec_ext <= (op_lo >= `CXD_MODE_EXT_FIRST); // RULE1
                dec_family <= op_hi;
                dec_mode <= mode_off[2:0];
            end
        end
    end

    // ----------------------------------------
    // Jump condition, address and stack
    // ----------------------------------------
    reg cond_pick;

    always @* begin
        case (COND_SEL_I[1:0]) // RULE3
            2'h0: cond_pick = carry;
            2'h1: cond_pick = ovfl;
            2'h2: cond_pick = zero;
            2'h3: cond_pick = sign;
            default: cond_pick = 1'b0;
        endcase
    end // RULE4 RULE6

    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            COND_TRUE_O <= 1'b0;
            EA_O <= 16'h0000;
            STACK_WE_O <= 1'b0;
            STACK_DATA_O <= `CXD_RST_BYTE;
            FLAGS_O <= `CXD_RST_BYTE;
        end else begin
            COND_TRUE_O <= cond_pick ^ COND_SEL_I[2];
            EA_O <= BASE_I + {{8{DISP_I[7]}}, DISP_I}; // RULE10
            STACK_WE_O <= INT_TAKE_I | TRAP_I | ILLEGAL_I; // RULE8
            if (INT_TAKE_I | TRAP_I | ILLEGAL_I) begin
                STACK_DATA_O <= flags_now; // RULE8 RULE12
            end
            FLAGS_O <= flags_now;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Answer prepared at setup so every output stays a flop
    reg [31:0] rd_mux;
    reg rd_err;

    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (PADDR_I)
            `CXD_OFS_FLAGS: rd_mux = {24'h000000, flags_now};
            `CXD_OFS_DECODE: rd_mux = {23'h000000, dec_valid, dec_ext,
                                       dec_family, dec_mode};
            `CXD_OFS_RESULT: rd_mux = {24'h000000, last_result};
            `CXD_OFS_CTRL: rd_mux = {31'h00000000, enable};
            default: rd_err = 1'b1;
        endcase
    end

    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
            enable <= `CXD_RST_CTRL;
        end else begin
            PREADY_O <= PSEL_I & ~PENABLE_I;
            if (PSEL_I & ~PENABLE_I) begin
                PSLVERR_O <= rd_err;
                PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_mux;
            end else begin
                PSLVERR_O <= 1'b0;
                PRDATA_O <= 32'h00000000;
            end
            if (wr_ctrl) begin
                enable <= PWDATA_I[0];
            end
        end
    end

endmodule

// ===== shared/cxd_defs.vh
`ifndef CXD_DEFS_VH
`define CXD_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CXD_OFS_FLAGS 12'h000
`define CXD_OFS_DECODE 12'h004
`define CXD_OFS_RESULT 12'h008
`define CXD_OFS_CTRL 12'h00C

// ----------------------------------------
// Status register bit positions
// ----------------------------------------
`define CXD_BIT_CARRY 7
`define CXD_BIT_ZERO 6
`define CXD_BIT_SIGN 5
`define CXD_BIT_OVFL 4
`define CXD_BIT_DECADJ 3
`define CXD_BIT_HALF 2
`define CXD_BIT_USER_TWO 1
`define CXD_BIT_USER_ONE 0

// ----------------------------------------
// Opcode high nibble: operation family
// ----------------------------------------
`define CXD_FAM_ADD 4'h0
`define CXD_FAM_ADC 4'h1
`define CXD_FAM_SUB 4'h2
`define CXD_FAM_SBC 4'h3
`define CXD_FAM_OR 4'h4
`define CXD_FAM_XOR 4'hB

// ----------------------------------------
// Opcode low nibble: operand mode range
// ----------------------------------------
`define CXD_MODE_FIRST 4'h2
`define CXD_MODE_LAST 4'h9
`define CXD_MODE_EXT_FIRST 4'h8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CXD_RST_COND 6'h00
`define CXD_RST_CTRL 1'b1
`define CXD_RST_BYTE 8'h00

`endif

// ===== tb/cxd_top_sva.sv
`include "cxd_defs.vh"
module cxd_top_sva (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // Inputs
    input wire logic PSEL_I, PWRITE_I, EXEC_I, INTERRUPT_RETURN_OP_I, INT_TAKE_I, TRAP_I, ILLEGAL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [7:0] OPCODE_I, DST_I, SRC_I, DISP_I, STACK_DATA_I,
    input wire logic [1:0] USER_SET_I, USER_CLR_I,
    input wire logic [2:0] COND_SEL_I,
    input wire logic [15:0] BASE_I,
    // Outputs
    input wire logic RESULT_WE_O, STACK_WE_O, COND_TRUE_O, PREADY_O,
    input wire logic [7:0] RESULT_O, FLAGS_O, STACK_DATA_O,
    input wire logic [15:0] EA_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // User bits are unknown until written, and reset leaves them so
    logic user_known = 1'h0;
    // Release edge skipped: outputs there still carry reset values
    logic armed;
    logic en_m;
    always @(posedge CLK_I or negedge RESET_N_I)
        if (!RESET_N_I)
            armed <= 1'h0;
        else
            armed <= 1'h1;
    // Execute enable as software last wrote it
    always @(posedge CLK_I or negedge RESET_N_I)
        if (!RESET_N_I)
            en_m <= `CXD_RST_CTRL;
        else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == `CXD_OFS_CTRL)
            en_m <= PWDATA_I[0];
    wire [7:0] xor_val = DST_I ^ SRC_I;
    wire xor_neg = xor_val[7];
    wire [2:0] kept = {FLAGS_O[7], FLAGS_O[3:2]};
    wire mode_ok = OPCODE_I[3:0] >= `CXD_MODE_FIRST && OPCODE_I[3:0] <= `CXD_MODE_LAST;
    always @(posedge CLK_I)
        if (RESET_N_I && (USER_SET_I | USER_CLR_I) != 2'h0)
            user_known <= 1'h1;
    function automatic int cond_pos(input logic [1:0] s);
        return s[1] ? (s[0] ? 5 : 6) : (s[0] ? 4 : 7);
    endfunction
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I || !armed);
    sequence s_xor_req;
        en_m && EXEC_I && OPCODE_I[7:4] == `CXD_FAM_XOR && mode_ok && !INTERRUPT_RETURN_OP_I;
    endsequence
    sequence s_push;
        user_known && (INT_TAKE_I || TRAP_I || ILLEGAL_I);
    endsequence
    AST_XOR_RESULT:
        assert property (s_xor_req |=> RESULT_WE_O && RESULT_O == $past(xor_val))
        else $error("xor result wrong");
    AST_XOR_FLAGS:
        assert property (s_xor_req |=> ##1 FLAGS_O[6:4] == {$past(xor_val, 2) == 8'h00,
            $past(xor_neg, 2), 1'h0} && kept == $past(kept)) else $error("xor flags wrong");
    AST_ADD_RESULT:
        assert property (en_m && EXEC_I && OPCODE_I[7:4] == `CXD_FAM_ADD && mode_ok |=>
            RESULT_WE_O && RESULT_O == 8'($past(DST_I) + $past(SRC_I))) else $error("add wrong");
    AST_STACK_PUSH:
        assert property (s_push |=> STACK_WE_O && STACK_DATA_O == FLAGS_O)
        else $error("status push wrong");
    AST_INTERRUPT_RETURN_OP_LOAD:
        assert property (INTERRUPT_RETURN_OP_I |=> ##1 FLAGS_O == $past(STACK_DATA_I, 2))
        else $error("status reload wrong");
    AST_COND:
        assert property (1'h1 |=> COND_TRUE_O ==
            (FLAGS_O[cond_pos($past(COND_SEL_I[1:0]))] ^ $past(COND_SEL_I[2])))
        else $error("jump condition wrong");
    AST_EA:
        assert property (1'h1 |=> EA_O == 16'($past(BASE_I) + {{8{$past(DISP_I[7])}},
            $past(DISP_I)})) else $error("displacement sum wrong");
    AST_USER_KEEP:
        assert property (user_known && !INTERRUPT_RETURN_OP_I && USER_SET_I == 2'h0 && USER_CLR_I == 2'h0
            && !(PSEL_I && PWRITE_I) |=> ##1 $stable(FLAGS_O[1:0]))
        else $error("user bits changed");
endmodule
bind cxd_top cxd_top_sva i_cxd_top_sva (.*);

// ===== tb/testbench.sv
`include "cxd_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_I = 1'h0, RESET_N_I = 1'h0, PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0;
    logic EXEC_I = 1'h0, INT_TAKE_I = 1'h0, TRAP_I = 1'h0, ILLEGAL_I = 1'h0, INTERRUPT_RETURN_OP_I = 1'h0;
    logic [11:0] PADDR_I = 12'h000;
    logic [31:0] PWDATA_I = 32'h0, rd;
    logic [7:0] OPCODE_I = 8'h00, DST_I = 8'h00, SRC_I = 8'h00, DISP_I = 8'h00;
    logic [7:0] STACK_DATA_I = 8'h00, r, f, lres = 8'h00;
    logic [1:0] USER_SET_I = 2'h0, USER_CLR_I = 2'h0;
    logic [2:0] COND_SEL_I = 3'h0;
    logic [15:0] BASE_I = 16'h0000;
    logic er, cy = 1'h0, en = 1'h1;
    wire [31:0] PRDATA_O;
    wire PREADY_O, PSLVERR_O, RESULT_WE_O, COND_TRUE_O, STACK_WE_O;
    wire [7:0] RESULT_O, STACK_DATA_O, FLAGS_O;
    wire [15:0] EA_O;
    int fails = 0, comparisons = 0;
    logic [7:0] exp_q[$];
    logic [7:0] ops[6] = '{8'h02, 8'h29, 8'h45, 8'h28, 8'hBA, 8'h52};
    cxd_top i_cxd_top (.*);
    initial forever #5 CLK_I = ~CLK_I;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        PSEL_I <= 1'h1;
        PWRITE_I <= wr;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'h1;
        do @(posedge CLK_I); while (PREADY_O !== 1'h1);
        rd = PRDATA_O;
        er = PSLVERR_O;
        PSEL_I <= 1'h0;
        PENABLE_I <= 1'h0;
    endtask
    // Only supported families leave a note; others must stay silent
    task automatic ex(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
        logic [7:0] e;
        @(posedge CLK_I);
        EXEC_I <= 1'h1;
        OPCODE_I <= op;
        DST_I <= d;
        SRC_I <= s;
        r = d ^ s;
        case (op[7:4])
            4'h0: e = 8'(d + s);
            4'h1: e = 8'(d + s + {7'h00, cy});
            4'h2: e = 8'(d - s);
            4'h3: e = 8'(d - s - {7'h00, cy});
            4'h4: e = d | s;
            default: e = r;
        endcase
        if (en && op[3:0] >= 4'h2 && op[3:0] <= 4'h9
            && (op[7:4] <= 4'h4 || op[7:4] == 4'hB)) begin
            exp_q.push_back(e);
            lres = e;
        end
        @(posedge CLK_I);
        EXEC_I <= 1'h0;
    endtask
    always @(posedge CLK_I) begin
        if (RESULT_WE_O === 1'h1 && exp_q.size() == 0)
            chk(32'h1, 32'h0);
        else if (RESULT_WE_O === 1'h1)
            chk(RESULT_O, exp_q.pop_front());
    end
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(25));
        repeat (20) @(posedge CLK_I);
        RESET_N_I <= 1'h1;
        @(posedge CLK_I);
        USER_CLR_I <= 2'h3;
        @(posedge CLK_I);
        USER_CLR_I <= 2'h0;
        apb(1'h0, `CXD_OFS_FLAGS, 32'h0);
        chk(rd, 32'h0);
        apb(1'h1, `CXD_OFS_FLAGS, 32'h8F);
        for (int i = 2; i < 10; i++)
            ex({4'hB, 4'(i)}, 8'($urandom), 8'($urandom));
        apb(1'h0, `CXD_OFS_FLAGS, 32'h0);
        chk(rd, {24'h0, 1'h1, r == 8'h00, r[7], 5'h0F});
        for (int i = 0; i < 6; i++)
            ex(ops[i], 8'($urandom), 8'($urandom));
        apb(1'h0, `CXD_OFS_DECODE, 32'h0);
        chk(rd, 32'h28);
        // Carry-in families with a known carry
        apb(1'h1, `CXD_OFS_FLAGS, 32'h80);
        cy = 1'h1;
        ex(8'h12, 8'h7F, 8'h00);
        apb(1'h0, `CXD_OFS_FLAGS, 32'h0);
        chk(rd, 32'h34);
        apb(1'h1, `CXD_OFS_FLAGS, 32'h80);
        ex(8'h33, 8'h00, 8'h00);
        apb(1'h0, `CXD_OFS_FLAGS, 32'h0);
        chk(rd, 32'hAC);
        // Execute disabled: decode still seen, no result
        apb(1'h1, `CXD_OFS_CTRL, 32'h0);
        en = 1'h0;
        ex(8'hB9, 8'($urandom), 8'($urandom));
        apb(1'h0, `CXD_OFS_DECODE, 32'h0);
        chk(rd, 32'h1DF);
        apb(1'h1, `CXD_OFS_CTRL, 32'h1);
        en = 1'h1;
        apb(1'h0, `CXD_OFS_RESULT, 32'h0);
        chk(rd, {24'h0, lres});
        // Patterns with H, D, carry and sign set against clear zero and overflow, and the reverse
        for (int j = 0; j < 2; j++) begin
            apb(1'h1, `CXD_OFS_FLAGS, j ? 32'h50 : 32'hAF);
            for (int i = 0; i < 8; i++) begin
                @(posedge CLK_I);
                COND_SEL_I <= 3'(i);
                repeat (2) @(posedge CLK_I);
                chk(COND_TRUE_O, ((j ? 4'h6 : 4'h9) >> i[1:0]) & 4'h1 ^ i[2]);
            end
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK_I);
            BASE_I <= 16'($urandom);
            DISP_I <= i[0] ? 8'h80 | 8'($urandom) : 8'h7F & 8'($urandom);
            repeat (2) @(posedge CLK_I);
            chk(EA_O, 16'(BASE_I + {{8{DISP_I[7]}}, DISP_I}));
        end
        apb(1'h1, `CXD_OFS_FLAGS, 32'h5A);
        for (int k = 0; k < 3; k++) begin
            @(posedge CLK_I);
            {INT_TAKE_I, TRAP_I, ILLEGAL_I} <= 3'h1 << k;
            @(posedge CLK_I);
            {INT_TAKE_I, TRAP_I, ILLEGAL_I} <= 3'h0;
            @(posedge CLK_I);
            chk({STACK_WE_O, STACK_DATA_O}, 32'h15A);
        end
        f = 8'($urandom);
        @(posedge CLK_I);
        INTERRUPT_RETURN_OP_I <= 1'h1;
        STACK_DATA_I <= f;
        @(posedge CLK_I);
        INTERRUPT_RETURN_OP_I <= 1'h0;
        STACK_DATA_I <= ~f;
        apb(1'h0, `CXD_OFS_FLAGS, 32'h0);
        chk(rd, {24'h0, f});
        @(posedge CLK_I);
        USER_SET_I <= 2'h2;
        USER_CLR_I <= 2'h3;
        @(posedge CLK_I);
        USER_SET_I <= 2'h0;
        USER_CLR_I <= 2'h0;
        @(posedge CLK_I);
        RESET_N_I <= 1'h0;
        repeat (3) @(posedge CLK_I);
        RESET_N_I <= 1'h1;
        apb(1'h0, `CXD_OFS_FLAGS, 32'h0);
        chk(rd, 32'h2);
        apb(1'h0, 12'h010, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        stop_test();
    end
endmodule
